// ---- src/sfc_pkg.sv ----
// shared constants for the serial flash command engine
package sfc_pkg;
    // command opcodes
    localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ   = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] CMD_READ          = 8'h03;
    localparam logic [7:0] CMD_FAST_READ     = 8'h0b;
    localparam logic [7:0] CMD_DUAL_READ     = 8'h3b;
    localparam logic [7:0] CMD_PAGE_PROGRAM  = 8'h02;
    // byte counts within a frame (count saturates at BC_DATA)
    localparam logic [2:0] BC_OPCODE = 3'h1;
    localparam logic [2:0] BC_STATUS = 3'h2;
    localparam logic [2:0] BC_ADDR   = 3'h4;
    localparam logic [2:0] BC_DATA   = 3'h5;
    // status byte layout
    localparam int SR_BUSY   = 0;
    localparam int SR_WEL    = 1;
    localparam int SR_BP_LO  = 2;
    localparam int SR_LOCK   = 7;
    localparam logic [7:0] SR_RESET = 8'h00;
    // page and timing
    localparam int PAGE_BYTES = 256;
    localparam int SYS_CLK_MHZ = 100;
    localparam int TIMER_W = 24;
    // self-timed cycle states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } cycle_state_t;
endpackage : sfc_pkg

// ---- src/serial_flash_cmd_engine.sv ----
// serial flash command decoder, status register and page program sequencer
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module serial_flash_cmd_engine #(
    parameter int MEM_ADDR_W            = 12,
    parameter int STATUS_WRITE_TIME_US  = 5000,
    parameter int PAGE_PROGRAM_TIME_US  = 600
) (
    // system
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // serial link
    input  wire logic       serial_clock,
    input  wire logic       select_n,
    input  wire logic       serial_in,
    input  wire logic       write_protect_pin_n,
    // data lines, line 1 is the serial output
    output var  logic       dual_line_0_out,
    output var  logic       dual_line_0_oe,
    output var  logic       dual_line_1_out,
    output var  logic       dual_line_1_oe,
    // status
    output var  logic       busy_flag,
    output var  logic       write_enable_latch,
    output var  logic [7:0] status_byte
);

    localparam int TW_CYC_I  = STATUS_WRITE_TIME_US * sfc_pkg::SYS_CLK_MHZ;
    localparam int TPP_CYC_I = PAGE_PROGRAM_TIME_US * sfc_pkg::SYS_CLK_MHZ;
    localparam logic [sfc_pkg::TIMER_W-1:0] TW_CYC  = sfc_pkg::TIMER_W'(TW_CYC_I);
    localparam logic [sfc_pkg::TIMER_W-1:0] TPP_CYC = sfc_pkg::TIMER_W'(TPP_CYC_I);

    // array content; written in the one cycle that a program starts (pp_start), read only when idle
    logic [7:0]  mem [2**MEM_ADDR_W];

    ////////////////////////////////////////////////////////////////////////////
    // link domain

    logic        fresh;
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_cnt;
    logic [6:0]  shreg;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic        refuse;
    logic [7:0]  page_buf [sfc_pkg::PAGE_BYTES];
    logic [sfc_pkg::PAGE_BYTES-1:0] page_mask;
    logic [7:0]  st_s1;
    logic [7:0]  status_l;
    logic        busy_l;
    logic [2:0]  b_cur;
    logic [2:0]  nb;
    logic [7:0]  in_byte;
    logic [3:0]  bit_sum;
    logic        data_ph;
    logic        dual_ph;
    logic        done;
    logic [7:0]  cur_byte;

    function automatic logic out_phase(input logic [7:0] op, input logic [2:0] bc);
        unique case (op)
            sfc_pkg::CMD_STATUS_READ: out_phase = bc != 3'h0;
            sfc_pkg::CMD_READ:        out_phase = bc >= sfc_pkg::BC_ADDR;
            sfc_pkg::CMD_FAST_READ,
            sfc_pkg::CMD_DUAL_READ:   out_phase = bc == sfc_pkg::BC_DATA;
            default:                  out_phase = 1'b0;
        endcase
    endfunction : out_phase

    // marks the first clock of a frame; no clock edges are needed to arm it
    always_ff @(posedge serial_clock or posedge select_n) begin
        if (select_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    always_comb begin
        b_cur    = fresh ? 3'h0 : bit_cnt;
        nb       = fresh ? 3'h0 : byte_cnt;
        in_byte  = {fresh ? 7'h00 : shreg, serial_in};
        data_ph  = !fresh && out_phase(opcode, byte_cnt);
        dual_ph  = data_ph && opcode == sfc_pkg::CMD_DUAL_READ;
        bit_sum  = {1'b0, b_cur} + (dual_ph ? 4'h2 : 4'h1);
        done     = bit_sum[3];
        busy_l   = status_l[sfc_pkg::SR_BUSY];
        cur_byte = opcode == sfc_pkg::CMD_STATUS_READ ? status_l : mem[addr[MEM_ADDR_W-1:0]];
    end

    // bit and byte counting, sampled on rising edges
    always_ff @(posedge serial_clock) begin
        bit_cnt <= bit_sum[2:0];
        shreg   <= in_byte[6:0];
        if (done && nb != sfc_pkg::BC_DATA) begin
            byte_cnt <= nb + 3'h1;
        end else begin
            byte_cnt <= nb;
        end
    end

    // opcode and address capture, address advance
    always_ff @(posedge serial_clock) begin
        if (done) begin
            if (nb == 3'h0) begin
                opcode <= in_byte;
                refuse <= busy_l;
            end else if (nb < sfc_pkg::BC_ADDR) begin
                addr <= {addr[15:0], in_byte};
            end else if (data_ph) begin
                addr <= addr + 24'h1;
            end else if (opcode == sfc_pkg::CMD_PAGE_PROGRAM) begin
                addr[7:0] <= addr[7:0] + 8'h1;
            end
        end
    end

    // page buffer; later bytes overwrite earlier ones at the same column
    always_ff @(posedge serial_clock) begin
        if (done && nb == 3'h0 && in_byte == sfc_pkg::CMD_PAGE_PROGRAM) begin
            page_mask <= '0;
        end else if (done && nb >= sfc_pkg::BC_ADDR && !busy_l
                     && opcode == sfc_pkg::CMD_PAGE_PROGRAM) begin
            page_buf[addr[7:0]]  <= in_byte;
            page_mask[addr[7:0]] <= 1'b1;
        end
    end

    // status levels into the link domain
    always_ff @(posedge serial_clock) begin
        st_s1    <= status_byte;
        status_l <= st_s1;
    end

    // output on falling edges; select high drops both drivers at once
    always_ff @(negedge serial_clock or posedge select_n) begin
        if (select_n) begin
            dual_line_1_out <= 1'b0;
            dual_line_1_oe  <= 1'b0;
            dual_line_0_out <= 1'b0;
            dual_line_0_oe  <= 1'b0;
        end else begin
            dual_line_1_out <= cur_byte[~bit_cnt];
            dual_line_0_out <= cur_byte[3'(3'h6 - bit_cnt)];
            dual_line_1_oe  <= data_ph && (opcode == sfc_pkg::CMD_STATUS_READ
                                           || !refuse);
            dual_line_0_oe  <= dual_ph && !refuse;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system domain: pin synchronisers

    logic [2:0]  sel_sync;
    logic        sel_q;
    logic [2:0]  wp_sync;
    logic        wp_q;
    logic        fr_s1;
    logic        fr_s2;
    logic        got_clk;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_sync <= 3'h7;
            sel_q    <= 1'b1;
            wp_sync  <= 3'h7;
            wp_q     <= 1'b1;
            fr_s1    <= 1'b1;
            fr_s2    <= 1'b1;
            got_clk  <= 1'b0;
        end else begin
            sel_sync <= {sel_sync[1:0], select_n};
            wp_sync  <= {wp_sync[1:0], write_protect_pin_n};
            if (sel_sync[2] == sel_sync[1]) begin
                sel_q <= sel_sync[2];
            end
            if (wp_sync[2] == wp_sync[1]) begin
                wp_q <= wp_sync[2];
            end
            fr_s1   <= fresh;
            fr_s2   <= fr_s1;
            // an empty select pulse must not replay the previous frame
            got_clk <= !sel_q && (got_clk || !fr_s2);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system domain: frame decode at select rise

    sfc_pkg::cycle_state_t        state;
    logic [sfc_pkg::TIMER_W-1:0]  timer;
    logic                         sr_lock;
    logic [2:0]                   bp;
    logic                         hpm;
    logic                         frame_ok;
    logic                         write_enable_cmd_ok;
    logic                         write_disable_cmd_ok;
    logic                         status_write_cmd_start;
    logic                         pp_start;
    logic                         cycle_end;

    // protected share grows from the bottom in eighths; top two levels cover all
    function automatic logic is_protected(input logic [2:0] lvl, input logic [2:0] region);
        is_protected = lvl[2:1] == 2'b11 || region < lvl;
    endfunction : is_protected

    // link registers are still while select is high, so they are read directly
    always_comb begin
        hpm        = sr_lock && !wp_q;
        frame_ok   = !sel_q && sel_sync[2] && sel_sync[1] && got_clk && bit_cnt == 3'h0;
        write_enable_cmd_ok    = frame_ok && byte_cnt == sfc_pkg::BC_OPCODE
                     && opcode == sfc_pkg::CMD_WRITE_ENABLE;
        write_disable_cmd_ok    = frame_ok && byte_cnt == sfc_pkg::BC_OPCODE
                     && opcode == sfc_pkg::CMD_WRITE_DISABLE;
        status_write_cmd_start = frame_ok && byte_cnt == sfc_pkg::BC_STATUS
                     && opcode == sfc_pkg::CMD_STATUS_WRITE
                     && write_enable_latch && !busy_flag && !hpm;
        pp_start   = frame_ok && byte_cnt == sfc_pkg::BC_DATA
                     && opcode == sfc_pkg::CMD_PAGE_PROGRAM
                     && write_enable_latch && !busy_flag
                     && !is_protected(bp, addr[MEM_ADDR_W-1 -: 3]);
        cycle_end  = state == sfc_pkg::ST_BUSY && timer == '0;
    end

    // self-timed cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state     <= sfc_pkg::ST_IDLE;
            timer     <= '0;
            busy_flag <= 1'b0;
        end else begin
            unique case (state)
                sfc_pkg::ST_IDLE: begin
                    if (status_write_cmd_start || pp_start) begin
                        state     <= sfc_pkg::ST_BUSY;
                        busy_flag <= 1'b1;
                        timer     <= (status_write_cmd_start ? TW_CYC : TPP_CYC) - 1'b1;
                    end
                end
                sfc_pkg::ST_BUSY: begin
                    if (timer == '0) begin
                        state     <= sfc_pkg::ST_IDLE;
                        busy_flag <= 1'b0;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
            endcase
        end
    end

    // write enable latch; a set in the same cycle as a clear wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            write_enable_latch <= 1'b0;
        end else begin
            if (cycle_end || pp_start || write_disable_cmd_ok) begin
                write_enable_latch <= 1'b0;
            end
            if (write_enable_cmd_ok) begin
                write_enable_latch <= 1'b1;
            end
        end
    end

    // writable status bits; the data byte lands in the low address byte
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sr_lock <= sfc_pkg::SR_RESET[sfc_pkg::SR_LOCK];
            bp      <= sfc_pkg::SR_RESET[sfc_pkg::SR_BP_LO +: 3];
        end else if (status_write_cmd_start) begin
            sr_lock <= addr[sfc_pkg::SR_LOCK];
            bp      <= addr[sfc_pkg::SR_BP_LO +: 3];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_byte <= sfc_pkg::SR_RESET;
        end else begin
            status_byte <= {sr_lock, 2'b00, bp, write_enable_latch, busy_flag};
        end
    end

    // page copy in one cycle, only columns that were sent
    always_ff @(posedge sys_clk) begin
        if (pp_start) begin
            for (int i = 0; i < sfc_pkg::PAGE_BYTES; i++) begin
                if (page_mask[i]) begin
                    mem[{addr[MEM_ADDR_W-1:8], 8'(i)}] <= page_buf[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [sfc_pkg::TIMER_W-1:0]  busy_run;
    always_ff @(posedge sys_clk) begin
        busy_run <= (rst || !busy_flag) ? '0 : busy_run + 1'b1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_write_enable_cmd_sets: assert property (write_enable_cmd_ok |=> write_enable_latch)
        else $error("latch not set after write enable");
    a_write_disable_cmd_clears: assert property (write_disable_cmd_ok && !write_enable_cmd_ok |=> !write_enable_latch)
        else $error("latch not cleared after write disable");
    a_end_clears_wel: assert property ($fell(busy_flag) && !$past(write_enable_cmd_ok)
        |-> !write_enable_latch) else $error("latch still set after cycle end");
    a_status_write_cmd_needs_wel: assert property (status_write_cmd_start |-> write_enable_latch)
        else $error("status write without latch");
    a_status_zero_bits: assert property (##1 status_byte[6:5] == 2'b00)
        else $error("reserved status bits not zero");
    a_status_write_cmd_busy_time: assert property (status_write_cmd_start |=> busy_flag [*8])
        else $error("busy dropped early after status write");
    a_hpm_blocks: assert property (hpm |-> !status_write_cmd_start)
        else $error("status write taken in protected mode");
    a_pp_clears_wel: assert property (pp_start |=> !write_enable_latch && busy_flag)
        else $error("program did not clear latch or raise busy");
    a_pp_aligned: assert property (pp_start |-> bit_cnt == 3'h0 && byte_cnt == 3'h5)
        else $error("program started on partial byte");
    a_pp_protect: assert property (pp_start |-> !is_protected(bp, addr[MEM_ADDR_W-1 -: 3]))
        else $error("program into protected region");
    a_busy_len: assert property ($rose(busy_flag) |-> busy_flag [*8])
        else $error("busy flag dropped too soon");
    a_busy_bound: assert property (busy_flag |-> busy_run < TW_CYC
        || busy_run < TPP_CYC) else $error("busy flag held too long");
    a_dual_pair: assert property (@(negedge serial_clock) disable iff (select_n)
        dual_line_0_oe |-> dual_line_1_oe)
        else $error("line 0 driven without line 1");
    a_read_refused: assert property (@(negedge serial_clock) disable iff (select_n)
        refuse && opcode == sfc_pkg::CMD_READ |-> !dual_line_1_oe)
        else $error("read answered while busy");
    c_status_write: cover property (status_write_cmd_start);
    c_page_program: cover property (pp_start);
    c_write_enable_cmd: cover property (write_enable_cmd_ok);
    c_dual_out: cover property (@(negedge serial_clock) dual_line_0_oe);
endmodule : serial_flash_cmd_engine
`default_nettype wire

// ---- test/spi_host_model.sv ----
// host side serial master model that drives frames into the flash engine
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    // link outputs
    output var  logic serial_clock,
    output var  logic select_n,
    output var  logic si,
    output var  logic si_oe,
    // data lines as resolved on the wire
    input  wire logic io0,
    input  wire logic io1
);
    localparam realtime HALF = 62.5;
    // clock stands low between frames, as a mode 0 master leaves it
    initial begin
        serial_clock = 1'b0;
        select_n     = 1'b1;
        si           = 1'b0;
        si_oe        = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic open_frame();
        select_n = 1'b0;
        #HALF;
    endtask : open_frame
    // bits launched in the low phase, sampled at the rising edge
    task automatic xfer(input logic [7:0] tx, input int nbits, input bit dual,
                        output logic [7:0] rx);
        int k;
        rx = 8'h00;
        si_oe = !dual;
        for (k = 0; k < nbits; k++) begin
            si = tx[7-k];
            #HALF;
            serial_clock = 1'b1;
            rx = dual ? {rx[5:0], io1, io0} : {rx[6:0], io1};
            #HALF;
            serial_clock = 1'b0;
        end
    endtask : xfer
    // select rises only after the last whole bit the caller asked for
    task automatic close_frame();
        si_oe = 1'b1;
        select_n = 1'b1;
        #100;
    endtask : close_frame
endmodule : spi_host_model
`default_nettype wire

// ---- test/serial_flash_cmd_engine_tb_top.sv ----
// self-checking bench for the serial flash command engine
`timescale 1ns/100ps
`default_nettype none
module serial_flash_cmd_engine_tb_top;
    logic       sys_clk, rst, write_protect_pin_n, toggle, oe_seen;
    logic       serial_clock, select_n, si, si_oe;
    logic       out0, oe0, out1, oe1, busy_flag, write_enable_latch;
    logic [7:0] status_byte;
    logic [7:0] tx [0:263];
    logic [7:0] rd [0:3];
    wire  logic io0;
    wire  logic io1;
    int         error_cnt, checks_done, cycles, k;
    // released lines show a moving pattern, not the last value
    assign io0 = oe0 ? out0 : (si_oe ? si : toggle);
    assign io1 = oe1 ? out1 : toggle;
    ////////////////////////////////////////////////////////////////////////////
    serial_flash_cmd_engine #(
        .MEM_ADDR_W           (12),
        .STATUS_WRITE_TIME_US (5),
        .PAGE_PROGRAM_TIME_US (8)
    ) u_serial_flash_cmd_engine (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .serial_clock        (serial_clock),
        .select_n            (select_n),
        .serial_in           (io0),
        .write_protect_pin_n (write_protect_pin_n),
        .dual_line_0_out     (out0),
        .dual_line_0_oe      (oe0),
        .dual_line_1_out     (out1),
        .dual_line_1_oe      (oe1),
        .busy_flag           (busy_flag),
        .write_enable_latch  (write_enable_latch),
        .status_byte         (status_byte)
    );
    spi_host_model u_spi_host_model (
        .serial_clock (serial_clock),
        .select_n     (select_n),
        .si           (si),
        .si_oe        (si_oe),
        .io0          (io0),
        .io1          (io1)
    );
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        toggle <= ~toggle;
        if (oe1 === 1'b1) oe_seen <= 1'b1;
        if (cycles == 80000) begin
            error_cnt++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one frame: nb bytes, a partial tail, then nrd bytes read back
    task automatic run(input logic [31:0] w, input int nb, input int tail, input int nrd,
                       input bit dual);
        int         n;
        logic [7:0] r;
        for (n = 0; n < 4 && n < nb; n++) tx[n] = w[31-8*n -: 8];
        u_spi_host_model.open_frame();
        for (n = 0; n < nb; n++) u_spi_host_model.xfer(tx[n], 8, 1'b0, r);
        if (tail > 0) u_spi_host_model.xfer(8'hff, tail, 1'b0, r);
        for (n = 0; n < nrd; n++) begin
            u_spi_host_model.xfer(8'h00, dual ? 4 : 8, dual, r);
            rd[n] = r;
        end
        u_spi_host_model.close_frame();
        repeat (10) @(posedge sys_clk);
        #1;
    endtask : run
    // polling bounded well past the longest self-timed cycle
    task automatic wait_idle();
        int n;
        for (n = 0; n < 2000 && busy_flag !== 1'b0; n++) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        #1;
        check({7'h0, busy_flag}, 8'h00);
    endtask : wait_idle
    task automatic results();
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        write_protect_pin_n = 1'b1;
        toggle = 1'b0;
        oe_seen = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (5) @(posedge sys_clk);
        check(status_byte, 8'h00);
        run(32'h06000000, 1, 0, 0, 0);
        check({7'h0, write_enable_latch}, 8'h01);
        run(32'h04000000, 1, 0, 0, 0);
        check({7'h0, write_enable_latch}, 8'h00);
        run(32'h01ec0000, 2, 0, 0, 0);
        check(status_byte, 8'h00);
        run(32'h06000000, 1, 0, 0, 0);
        run(32'h01ec0000, 1, 7, 0, 0);
        check(status_byte, 8'h02);
        run(32'h01ec0000, 2, 0, 0, 0);
        check({7'h0, busy_flag}, 8'h01);
        run(32'h05000000, 1, 0, 2, 0);
        check(rd[1], 8'h8f);
        wait_idle();
        check(status_byte, 8'h8c);
        @(posedge sys_clk);
        #1 write_protect_pin_n = 1'b0;
        run(32'h06000000, 1, 0, 0, 0);
        run(32'h01000000, 2, 0, 0, 0);
        check({7'h0, busy_flag}, 8'h00);
        check(status_byte & 8'hfd, 8'h8c);
        @(posedge sys_clk);
        #1 write_protect_pin_n = 1'b1;
        run(32'h01040000, 2, 0, 0, 0);
        wait_idle();
        check(status_byte, 8'h04);
        run(32'h06000000, 1, 0, 0, 0);
        tx[4] = 8'h55;
        run(32'h02000010, 5, 0, 0, 0);
        check({7'h0, busy_flag}, 8'h00);
        run(32'h01000000, 2, 0, 0, 0);
        wait_idle();
        check(status_byte, 8'h00);
        run(32'h02000200, 5, 0, 0, 0);
        check({7'h0, busy_flag}, 8'h00);
        run(32'h06000000, 1, 0, 0, 0);
        run(32'h02000200, 5, 3, 0, 0);
        check({7'h0, busy_flag}, 8'h00);
        // 258 bytes from column fe: the first two get overwritten
        for (k = 0; k < 258; k++) tx[k+4] = k[7:0] ^ {7'h0, k[8]};
        run(32'h020002fe, 262, 0, 0, 0);
        check({7'h0, busy_flag}, 8'h01);
        check({7'h0, write_enable_latch}, 8'h00);
        oe_seen = 1'b0;
        run(32'h030002fe, 4, 0, 1, 0);
        check({7'h0, oe_seen}, 8'h00);
        wait_idle();
        run(32'h030002fe, 4, 0, 2, 0);
        check(rd[0], 8'h01);
        check(rd[1], 8'h00);
        check({7'h0, oe1}, 8'h00);
        tx[4] = 8'h00;
        run(32'h0b000200, 5, 0, 2, 0);
        check(rd[0], 8'h02);
        check(rd[1], 8'h03);
        run(32'h3b0002fc, 5, 0, 2, 1);
        check(rd[0], 8'hfe);
        check(rd[1], 8'hff);
        results();
    end
endmodule : serial_flash_cmd_engine_tb_top
`default_nettype wire
